/* File: rtl/dsa_pkg.sv */
// constants for the sound-field dsp serial audio ports: register map, control fields, formats and timing.
// assumes a 100 MHz apb clock and a 24-bit internal data bus word.
package dsa_pkg;
   // apb register byte offsets
   localparam logic [7:0]  OFS_CTRL      = 8'h00;   // control fields
   localparam logic [7:0]  OFS_STATUS    = 8'h04;   // link state
   localparam logic [7:0]  OFS_GIN_L     = 8'h08;   // general input, left word
   localparam logic [7:0]  OFS_GIN_R     = 8'h0C;   // general input, right word
   localparam logic [7:0]  OFS_AIN_L     = 8'h10;   // adc input, left word
   localparam logic [7:0]  OFS_AIN_R     = 8'h14;   // adc input, right word
   // control field positions and reset value
   localparam int          CTL_RATE_LSB  = 0;       // bit_clock_rate_field, 2 bits
   localparam int          CTL_GIN_LSB   = 2;       // general_in_format_field, 2 bits
   localparam int          CTL_GOUT_LSB  = 4;       // general_out_format_field, 2 bits
   localparam int          CTL_AIN_BIT   = 6;       // adc_in_length_bit
   localparam int          CTL_D1_BIT    = 7;       // dac1_out_length_bit
   localparam int          CTL_MASTER    = 8;       // 1: device makes both clocks
   localparam int          CTL_ADC_LOOP  = 9;       // 1: adc input port fed by internal adc
   localparam int          CTL_WIDTH     = 10;
   localparam logic [9:0]  CTL_RESET     = 10'h000;
   // bit clock rate codes
   localparam logic [1:0]  RATE_64       = 2'h0;
   localparam logic [1:0]  RATE_48       = 2'h2;
   localparam logic [1:0]  RATE_32       = 2'h1;
   // slots per half sample period
   localparam logic [5:0]  HALF_64       = 6'h20;
   localparam logic [5:0]  HALF_48       = 6'h18;
   localparam logic [5:0]  HALF_32       = 6'h10;
   // word lengths
   localparam logic [5:0]  LEN_16        = 6'h10;
   localparam logic [5:0]  LEN_20        = 6'h14;
   localparam logic [5:0]  LEN_24        = 6'h18;
   // two-bit format codes of the general ports
   localparam logic [1:0]  FMT_M16       = 2'h0;
   localparam logic [1:0]  FMT_M24       = 2'h1;
   localparam logic [1:0]  FMT_L16       = 2'h2;
   localparam logic [1:0]  FMT_L24       = 2'h3;
   // holding register destinations named by the program
   localparam logic [2:0]  DST_GEN_L     = 3'h0;
   localparam logic [2:0]  DST_GEN_R     = 3'h1;
   localparam logic [2:0]  DST_D1_L      = 3'h2;
   localparam logic [2:0]  DST_D1_R      = 3'h3;
   localparam logic [2:0]  DST_D2_L      = 3'h4;
   localparam logic [2:0]  DST_D2_R      = 3'h5;
   // input sources read by the program; others read as zero
   localparam logic [2:0]  SRC_GIN_L     = 3'h0;
   localparam logic [2:0]  SRC_GIN_R     = 3'h1;
   localparam logic [2:0]  SRC_AIN_L     = 3'h2;
   localparam logic [2:0]  SRC_AIN_R     = 3'h3;
   // master bit clock: 160 ns period from the 10 ns clock
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          BCLK_NS       = 160;
   localparam int          BCLK_HALF_CYC = BCLK_NS / (2 * CLK_PERIOD_NS);
   localparam logic [5:0]  MASTER_BITS   = 6'h3F;   // last bit index of a 64-bit frame
endpackage : dsa_pkg

/* File: rtl/dsa_serial_ports.sv */
// serial audio port logic of the sound-field dsp: two input ports, six serial outputs, master clock maker.
// assumes an apb master on pclk, a dsp core on pclk writing holding registers, and pins from another domain.
// Function
// - general output: 24/16 msb or 16 lsb
// - dac1 output port: 20/16 msb only
// - holding register loads on program write strobe
// - msb outputs send previous period's sample
// - frame rise copies holds into shift words
// - writes near period end may miss
// - master drives frame and 64fs bit clock
// - inputs sampled on bit clock rise
// - outputs change on bit clock fall
// - rate field selects 64, 48, 32 bits
// - general input format field four formats
// - general output format field three formats
// - at 32fs general ports 16 msb
// - adc input length bit, 20 or 16
// - adc serial output 20 or 16 bits
// - dac1 output length bit, 20 or 16
// - dac1 serial input always 20 msb
// - dac2 port and input 20 msb
// - input words latched, shown next period
// - adc input connectable internally to the internal adc
//
// The register addresses and register access over APB were decided locally.
module dsa_serial_ports
   import dsa_pkg::*;
#(
   parameter int BCLK_HALF = BCLK_HALF_CYC       // pclk cycles per master bit clock half period
)(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // dsp core side on pclk
   input  wire logic        core_wr_stb,
   input  wire logic [2:0]  core_dest_sel,
   input  wire logic [23:0] internal_data_bus,
   input  wire logic [2:0]  source_select_field,
   output logic      [23:0] core_rd_data,
   input  wire logic [19:0] adc_sample_l,
   input  wire logic [19:0] adc_sample_r,
   // serial clocks, two-way
   input  wire logic        frame_clock_in,
   output logic             frame_clock_out,
   output logic             frame_clock_oe_n,
   input  wire logic        bit_clock_in,
   output logic             bit_clock_out,
   output logic             bit_clock_oe_n,
   // serial data
   input  wire logic        general_in_port,
   input  wire logic        adc_in_port,
   output logic             general_out_port,
   output logic             dac1_out_port,
   output logic             dac1_serial_input,
   output logic             dac2_out_port,
   output logic             dac2_serial_input,
   output logic             adc_serial_output
);
   localparam int NOUT = 6;                      // serial outputs
   localparam int NIN  = 2;                      // serial inputs

   // bit of a left-aligned word for a slot, zero outside the word
   function automatic logic bit_at(input logic [23:0] w, input logic [5:0] len, input logic lsb,
                                   input logic [5:0] slot, input logic [5:0] half);
      logic [5:0] k;
      logic       ok;
      k  = lsb ? 6'(slot - (half - len)) : slot;
      ok = lsb ? (slot >= 6'(half - len)) : (slot < len);
      return ok ? w[5'(6'h17 - k)] : 1'b0;
   endfunction

   // received half period to left-aligned word, low bits zero
   function automatic logic [23:0] rx_align(input logic [31:0] sh, input logic [5:0] len, input logic lsb,
                                             input logic [5:0] half);
      logic [31:0] t;
      t = lsb ? (sh << 6'(6'h20 - len)) : (sh << 6'(6'h20 - half));
      return t[31:8] & ~(24'hFFFFFF >> len);
   endfunction

   // control register and derived formats
   logic [CTL_WIDTH-1:0] ctrl_q;
   logic                 master;
   logic [5:0]           half;
   logic [5:0]           gin_len, gout_len, ain_len, d1_len, adc_len;
   logic                 gin_lsb, gout_lsb;
   logic [1:0]           gin_fmt, gout_fmt;

   always_comb begin
      master   = ctrl_q[CTL_MASTER];
      gin_fmt  = ctrl_q[CTL_GIN_LSB +: 2];
      gout_fmt = ctrl_q[CTL_GOUT_LSB +: 2];
      // master mode always runs 64 bits per period; the unlisted code 11 is taken as 64
      if (master || ctrl_q[CTL_RATE_LSB +: 2] == RATE_64 || ctrl_q[CTL_RATE_LSB +: 2] == 2'h3) begin
         half = HALF_64;
      end else if (ctrl_q[CTL_RATE_LSB +: 2] == RATE_48) begin
         half = HALF_48;
      end else begin
         half = HALF_32;
      end
      // general input formats; 24 lsb only fits a 32-slot half
      gin_len  = (gin_fmt == FMT_M24 || gin_fmt == FMT_L24) ? LEN_24 : LEN_16;
      gin_lsb  = (gin_fmt == FMT_L16) || (gin_fmt == FMT_L24 && half == HALF_64);
      // general output formats; code 11 falls back to 16 msb
      gout_len = (gout_fmt == FMT_M24) ? LEN_24 : LEN_16;
      gout_lsb = (gout_fmt == FMT_L16);
      ain_len  = ctrl_q[CTL_AIN_BIT] ? LEN_16 : LEN_20;
      d1_len   = ctrl_q[CTL_D1_BIT] ? LEN_16 : LEN_20;
      adc_len  = (half == HALF_32) ? LEN_16 : LEN_20;
      // a 16-slot half only carries 16-bit msb words whatever the fields say
      if (half == HALF_32) begin
         gin_len  = LEN_16;
         gin_lsb  = 1'b0;
         gout_len = LEN_16;
         gout_lsb = 1'b0;
         ain_len  = LEN_16;
         d1_len   = LEN_16;
      end
   end

   // master clock maker: divider toggles the bit clock, frame flips every 32 bits
   logic [$clog2(BCLK_HALF+1)-1:0] div_q;
   logic                           mbclk_q, mframe_q;
   logic [5:0]                     mbit_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q    <= '0;
         mbclk_q  <= 1'b1;
         mframe_q <= 1'b0;
         mbit_q   <= 6'h00;
      end else if (!master) begin
         div_q    <= '0;                         // held still so the first master bit is whole
         mbclk_q  <= 1'b1;
      end else if (div_q == ($clog2(BCLK_HALF+1))'(BCLK_HALF - 1)) begin
         div_q   <= '0;
         mbclk_q <= ~mbclk_q;
         if (mbclk_q) begin
            // falling edge: advance the bit and flip the frame at each half boundary
            mbit_q <= (mbit_q == MASTER_BITS) ? 6'h00 : 6'(mbit_q + 6'h01);
            if (mbit_q == MASTER_BITS) begin
               mframe_q <= 1'b1;
            end else if (mbit_q == 6'h1F) begin
               mframe_q <= 1'b0;
            end
         end
      end else begin
         div_q <= ($clog2(BCLK_HALF+1))'(div_q + 1'b1);
      end
   end

   // clock pins: drive in master mode, oe low while driving
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_clock_out  <= 1'b0;
         bit_clock_out    <= 1'b1;
         frame_clock_oe_n <= 1'b1;
         bit_clock_oe_n   <= 1'b1;
      end else begin
         frame_clock_out  <= mframe_q;
         bit_clock_out    <= mbclk_q;
         frame_clock_oe_n <= ~master;
         bit_clock_oe_n   <= ~master;
      end
   end

   // synchronisers; master mode feeds its own clocks through the same depth so data stays aligned
   logic [3:0] s1_q, s2_q;
   logic       bclk_prev_q, fall_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q        <= 4'h0;
         s2_q        <= 4'h0;
         bclk_prev_q <= 1'b1;
         fall_q      <= 1'b0;
      end else begin
         s1_q        <= {master ? mbclk_q : bit_clock_in, master ? mframe_q : frame_clock_in,
                         general_in_port, adc_in_port};
         s2_q        <= s1_q;
         bclk_prev_q <= s2_q[3];
         fall_q      <= bclk_prev_q & ~s2_q[3];  // a cycle late so the frame level has settled
      end
   end

   logic rise_ev, frame_s, ain_bit;
   assign rise_ev = ~bclk_prev_q & s2_q[3];
   assign frame_s = s2_q[2];
   assign ain_bit = ctrl_q[CTL_ADC_LOOP] ? adc_serial_output : s2_q[0];

   // slot counter per half; a frame level change at a fall opens a new half
   logic [5:0] slot_q, slot_nx;
   logic       frame_prev_q, half_end, frame_rise;
   assign half_end   = fall_q & (frame_s != frame_prev_q);
   assign frame_rise = half_end & frame_s;                              // frame high is the left half
   assign slot_nx    = half_end ? 6'h00 : ((slot_q == 6'h3F) ? slot_q : 6'(slot_q + 6'h01));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_q       <= 6'h00;
         frame_prev_q <= 1'b0;
      end else if (fall_q) begin
         slot_q       <= slot_nx;
         frame_prev_q <= frame_s;
      end
   end

   // holding registers written by the program, the whole 24-bit bus word
   logic [23:0] hold_q [NOUT];
   logic [23:0] ps_q   [NOUT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 6; i++) begin
            hold_q[i] <= 24'h000000;
         end
      end else if (core_wr_stb && core_dest_sel <= DST_D2_R) begin
         // a write just before the frame rise may land after the copy; program must keep clear
         hold_q[core_dest_sel] <= internal_data_bus;
      end
   end

   // shift words: copied at frame rise, so outputs carry last period's sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 6; i++) begin
            ps_q[i] <= 24'h000000;
         end
      end else if (frame_rise) begin
         for (int i = 0; i < 6; i++) begin
            ps_q[i] <= hold_q[i];
         end
      end
   end

   // internal adc words latched with the frame, left-aligned
   logic [23:0] adcw_q [2];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adcw_q[0] <= 24'h000000;
         adcw_q[1] <= 24'h000000;
      end else if (frame_rise) begin
         adcw_q[0] <= {adc_sample_l, 4'h0};
         adcw_q[1] <= {adc_sample_r, 4'h0};
      end
   end

   // per-output word source and format; the left half uses the word copied this very edge
   logic [23:0] ow_l [NOUT], ow_r [NOUT];
   logic [5:0]  olen [NOUT];
   logic        olsb [NOUT];
   logic        obit_q [NOUT];
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         ow_l[2*i] = frame_rise ? hold_q[2*i] : ps_q[2*i];
         ow_r[2*i] = ps_q[2*i+1];
      end
      ow_l[1] = ow_l[2];                          // dac1 serial input shares dac1 port words
      ow_r[1] = ow_r[2];
      ow_l[3] = ow_l[4];                          // dac2 serial input shares dac2 port words
      ow_r[3] = ow_r[4];
      ow_l[5] = frame_rise ? {adc_sample_l, 4'h0} : adcw_q[0];
      ow_r[5] = adcw_q[1];
      olen[0] = gout_len;  olsb[0] = gout_lsb;
      olen[1] = LEN_20;    olsb[1] = 1'b0;
      olen[2] = d1_len;    olsb[2] = 1'b0;
      olen[3] = LEN_20;    olsb[3] = 1'b0;
      olen[4] = LEN_20;    olsb[4] = 1'b0;
      olen[5] = adc_len;   olsb[5] = 1'b0;
   end

   // serialisers: one bit per slot, changed only at the bit clock fall
   for (genvar g = 0; g < NOUT; g++) begin : g_out
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            obit_q[g] <= 1'b0;
         end else if (fall_q) begin
            obit_q[g] <= bit_at(frame_s ? ow_l[g] : ow_r[g], olen[g], olsb[g], slot_nx, half);
         end
      end
   end
   assign general_out_port  = obit_q[0];
   assign dac1_serial_input = obit_q[1];
   assign dac1_out_port     = obit_q[2];
   assign dac2_serial_input = obit_q[3];
   assign dac2_out_port     = obit_q[4];
   assign adc_serial_output = obit_q[5];

   // receivers: shift on the rise, cut the word out at each half end
   logic [31:0] rsh_q  [NIN];
   logic [23:0] rxh_q  [NIN];                     // left word waiting for its partner
   logic [23:0] rxv_q  [2*NIN];                   // words shown to the bus, l/r per port
   logic [5:0]  ilen   [NIN];
   logic        ilsb   [NIN];
   logic        ibit   [NIN];
   always_comb begin
      ilen[0] = gin_len;  ilsb[0] = gin_lsb;  ibit[0] = s2_q[1];
      ilen[1] = ain_len;  ilsb[1] = 1'b0;     ibit[1] = ain_bit;
   end

   for (genvar g = 0; g < NIN; g++) begin : g_in
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rsh_q[g] <= 32'h00000000;
         end else if (rise_ev) begin
            rsh_q[g] <= {rsh_q[g][30:0], ibit[g]};
         end
      end
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rxh_q[g]     <= 24'h000000;
            rxv_q[2*g]   <= 24'h000000;
            rxv_q[2*g+1] <= 24'h000000;
         end else if (half_end && !frame_s) begin
            rxh_q[g] <= rx_align(rsh_q[g], ilen[g], ilsb[g], half);
         end else if (frame_rise) begin
            // pair complete: shown on the bus through the next period
            rxv_q[2*g]   <= rxh_q[g];
            rxv_q[2*g+1] <= rx_align(rsh_q[g], ilen[g], ilsb[g], half);
         end
      end
   end

   // program reads of the input words; no source drives zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_rd_data <= 24'h000000;
      end else if (source_select_field <= SRC_AIN_R) begin
         core_rd_data <= rxv_q[source_select_field[1:0]];
      end else begin
         core_rd_data <= 24'h000000;
      end
   end

   // frame counter for status
   logic [15:0] frames_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frames_q <= 16'h0000;
      end else if (frame_rise) begin
         frames_q <= frames_q + 16'h0001;
      end
   end

   // apb slave: answer prepared in setup, pready high in the first access cycle
   logic        hit;
   logic [31:0] rd;
   always_comb begin
      hit = 1'b1;
      unique case (paddr)
         OFS_CTRL:   rd = {22'h0, ctrl_q};
         OFS_STATUS: rd = {frames_q, 7'h00, frame_s, 2'h0, slot_q};
         OFS_GIN_L:  rd = {8'h00, rxv_q[0]};
         OFS_GIN_R:  rd = {8'h00, rxv_q[1]};
         OFS_AIN_L:  rd = {8'h00, rxv_q[2]};
         OFS_AIN_R:  rd = {8'h00, rxv_q[3]};
         default: begin
            rd  = 32'h00000000;          // unmapped reads zero with an error
            hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable & ~pready;
         prdata  <= (psel & ~penable & ~pwrite) ? rd : 32'h00000000;
         pslverr <= psel & ~penable & ~hit;
      end
   end

   // control write at the completing access edge; only the control register is writable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTL_RESET;
      end else if (psel && penable && pready && pwrite && paddr == OFS_CTRL) begin
         ctrl_q <= pwdata[CTL_WIDTH-1:0];
      end
   end

   // checks
   a_out_on_fall: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(general_out_port) |-> $past(fall_q)) else $error("output changed off a fall");
   a_rx_on_rise: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(rsh_q[0]) |-> $past(rise_ev)) else $error("input shifted off a rise");
   a_master_64: assert property (@(posedge pclk) disable iff (!presetn)
      master |-> half == HALF_64) else $error("master not 64 slots");
   a_ps_on_frame: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(ps_q[0]) |-> $past(frame_rise)) else $error("shift word loaded off frame rise");
   a_hold_on_wr: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(hold_q[4]) |-> $past(core_wr_stb) && $past(core_dest_sel) == DST_D2_L) else $error("hold loaded unasked");
   a_rate32_fmt: assert property (@(posedge pclk) disable iff (!presetn)
      half == HALF_32 |-> gin_len == LEN_16 && gout_len == LEN_16 && !gin_lsb && !gout_lsb) else $error("32fs format");
   a_adc_len: assert property (@(posedge pclk) disable iff (!presetn)
      (half != HALF_32) == (adc_len == LEN_20)) else $error("adc output length");
   a_unused_low: assert property (@(posedge pclk) disable iff (!presetn)
      fall_q && slot_nx >= LEN_20 |=> !dac2_out_port) else $error("unused slot not low");
   a_bus_pad: assert property (@(posedge pclk) disable iff (!presetn)
      frame_rise && gin_len == LEN_16 |=> rxv_q[1][7:0] == 8'h00) else $error("input word not zero padded");
endmodule : dsa_serial_ports

/* File: dv/dsa_codec_model.sv */
// external codec: slave frame and bit clocks, sends one left word, captures one left word.
// assumes 64 slots per frame, frame clock high for the left half.
module dsa_codec_model (
   // clocks made for the device
   output logic        bclk,
   output logic        fclk,
   // serial data
   output logic        sdo,
   input  wire logic   sdi,
   // words
   input  wire logic [31:0] tx_left,
   output logic [31:0] rx_left,
   output logic        rx_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   int slot;                                       // slot within the frame
   // 160 ns bit clock, frames back to back
   initial begin
      {bclk, fclk, sdo, rx_valid, rx_left, slot} = {3'h4, 1'h0, 32'h0, 0};
      forever begin
         #80 bclk = 0;
         fclk = (slot < 32);
         sdo = (slot < 32) ? tx_left[31 - slot] : ~sdo; // change on fall
         #80 bclk = 1;
         if (slot < 32) rx_left[31 - slot] = sdi;     // sample on rise
         rx_valid = (slot == 31);
         slot = (slot + 1) % 64;
      end
   end
endmodule // dsa_codec_model

/* File: dv/tb.sv */
// self-checking bench: apb setup, holding writes, serial loop through the codec model.
// assumes slave clocks from the model unless master mode is set.
module tb;
   import dsa_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, core_wr_stb = 0, e, pready, pslverr;
   logic [7:0]  paddr = 0;
   logic [2:0]  core_dest_sel = 0, source_select_field = 0;
   logic [23:0] internal_data_bus = 0, core_rd_data, w;
   logic [31:0] pwdata = 0, prdata, r, tx_left = 0, rx_left, exp_q[$];
   logic        fo, foe_n, bo, boe_n, m_f, m_b, gin, gout, rx_valid;
   int          err_total = 0, num_checks = 0, seed = 30291, n;
   wire         fclk = foe_n ? m_f : fo;              // shared frame clock wire
   wire         bclk = boe_n ? m_b : bo;              // shared bit clock wire
   always #5 pclk = ~pclk;
   dsa_codec_model i_dsa_codec_model (.bclk(m_b), .fclk(m_f), .sdo(gin), .sdi(gout), .tx_left(tx_left),
      .rx_left(rx_left), .rx_valid(rx_valid));
   dsa_serial_ports i_dsa_serial_ports (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_wr_stb(core_wr_stb), .core_dest_sel(core_dest_sel), .internal_data_bus(internal_data_bus),
      .source_select_field(source_select_field), .core_rd_data(core_rd_data), .adc_sample_l(20'h0),
      .adc_sample_r(20'h0), .frame_clock_in(fclk), .frame_clock_out(fo), .frame_clock_oe_n(foe_n),
      .bit_clock_in(bclk), .bit_clock_out(bo), .bit_clock_oe_n(boe_n), .general_in_port(gin),
      .adc_in_port(1'b0), .general_out_port(gout), .dac1_out_port(), .dac1_serial_input(),
      .dac2_out_port(), .dac2_serial_input(), .adc_serial_output());
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata; e = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // serial monitor: oldest expected left word against the next captured one, while any is queued
   always @(posedge rx_valid) if (exp_q.size() > 0) chk(rx_left, exp_q.pop_front());
   initial begin
      #600us err_total++;
      report_and_stop;
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, OFS_CTRL, 0); chk(r, 32'(CTL_RESET));
      apb(0, 8'hFC, 0);
      chk(r, 32'h0);
      chk(32'(e), 32'h1);
      for (int f = 0; f < 3; f++) begin
         apb(1, OFS_CTRL, 32'((f << CTL_GOUT_LSB) | (f << CTL_GIN_LSB)));
         apb(0, OFS_CTRL, 0); chk(r, 32'((f << CTL_GOUT_LSB) | (f << CTL_GIN_LSB)));
         @(negedge fclk) w = 24'($random(seed));
         @(posedge pclk) {core_dest_sel, internal_data_bus, core_wr_stb} <= {DST_GEN_L, w, 1'b1};
         @(posedge pclk) core_wr_stb <= 0;
         case (f)
            0: begin tx_left <= {w[23:8], 16'hFFFF}; exp_q.push_back({w[23:8], 16'h0}); end
            1: begin tx_left <= {w, 8'hFF}; exp_q.push_back({w, 8'h0}); end
            default: begin tx_left <= {16'hFFFF, w[23:8]}; exp_q.push_back({16'h0, w[23:8]}); end
         endcase
         repeat (3) @(posedge fclk);
         @(posedge pclk) source_select_field <= SRC_GIN_L;
         repeat (3) @(posedge pclk);
         chk(core_rd_data, (f == 1) ? w : {w[23:8], 8'h0});
      end
      apb(1, OFS_CTRL, 32'h100);
      @(posedge fo) n = 0;
      fork : cnt
         forever @(posedge bo) n++;
         @(posedge fo) disable cnt;
      join
      chk(n, 64);
      chk(foe_n, 0);
      report_and_stop;
   end
endmodule // tb
